//--- verilog/rmd_pkg.sv
// Constants and types shared by both ends of the register move and data op link.
// Assumes both ends run on one clock and exchange 16-bit command words.
package rmd_pkg;
    // ************************************************************
    // Widths
    // ************************************************************
    localparam int WORD_W = 16;
    localparam int DATA_W = 32;

    // ************************************************************
    // Command codes and lengths in words
    // ************************************************************
    localparam logic [15:0] CODE_REG_MOVE_ABS_TIME     = 16'h00ec;
    localparam logic [15:0] CODE_REG_MOVE_REL_TIME     = 16'h00eb;
    localparam logic [15:0] CODE_REG_MOVE_ABS_VELOCITY = 16'h00ea;
    localparam logic [15:0] CODE_REG_MOVE_REL_VELOCITY = 16'h00e9;
    localparam logic [15:0] CODE_ADD_TO_DATA_REGISTER  = 16'h00f8;
    localparam logic [15:0] CODE_CHECK_STATUS_REPORT   = 16'h00a4;
    localparam logic [2:0]  LEN_NONE  = 3'h0;
    localparam logic [2:0]  LEN_MOVE  = 3'h4;
    localparam logic [2:0]  LEN_ADD   = 3'h4;
    localparam logic [2:0]  LEN_CHECK = 3'h3;
    localparam logic [2:0]  LEN_MAX   = 3'h4;

    // ************************************************************
    // Parameter word positions and register offsets
    // ************************************************************
    localparam int PW_IDX     = 1;
    localparam int PW_STOP_EN = 2;
    localparam int PW_STOP_ST = 3;
    localparam int PW_DATA_HI = 2;
    localparam int PW_DATA_LO = 3;
    localparam int PW_COND_EN = 1;
    localparam int PW_COND_ST = 2;
    localparam int OFS_ACCEL  = 1;
    localparam int OFS_TOTAL  = 2;
    localparam int PSW_CHECK_BIT = 6;
    localparam logic THREAD_ONE  = 1'b0;

    // ************************************************************
    // Host register map, byte addresses and fields
    // ************************************************************
    localparam logic [7:0] ADR_WORD0 = 8'h00;
    localparam logic [7:0] ADR_WORD1 = 8'h04;
    localparam logic [7:0] ADR_WORD2 = 8'h08;
    localparam logic [7:0] ADR_WORD3 = 8'h0c;
    localparam logic [7:0] ADR_CTRL  = 8'h10;
    localparam logic [7:0] ADR_STAT  = 8'h14;
    localparam logic [7:0] ADR_ISTAT = 8'h18;
    localparam logic [7:0] ADR_IMASK = 8'h1c;
    localparam int CTRL_GO      = 0;
    localparam int CTRL_THREAD  = 1;
    localparam int CTRL_LEN_LSB = 4;
    localparam int STAT_BUSY    = 0;
    localparam int STAT_NAK     = 1;
    localparam int IRQ_DONE     = 0;
    localparam int IRQ_NAK      = 1;
    localparam int IRQ_W        = 2;

    typedef enum logic [1:0] {RMD_RX_CODE, RMD_RX_PARAM, RMD_EXEC} rmd_dev_state_t;
    typedef enum logic [1:0] {RMD_H_IDLE, RMD_H_SEND, RMD_H_WAIT} rmd_host_state_t;
endpackage

//--- verilog/rmd_link_if.sv
// Command link between the host end and the device end.
// Assumes both ends share one clock; the bench instantiates and joins them.
`timescale 1ns/1ps
interface rmd_link_if;
    logic                           cmd_valid;
    logic [rmd_pkg::WORD_W-1:0]     cmd_word;
    logic                           cmd_thread;
    logic                           cmd_ready;
    logic                           rsp_valid;
    logic                           rsp_nak;
    modport dev  (input cmd_valid, cmd_word, cmd_thread, output cmd_ready, rsp_valid, rsp_nak);
    modport host (output cmd_valid, cmd_word, cmd_thread, input cmd_ready, rsp_valid, rsp_nak);
endinterface

//--- verilog/rmd_cond_test.sv
// Condition test on the internal status word, shared with the jump logic.
// Assumes all inputs are stable within the cycle; purely combinational.
`timescale 1ns/1ps
module rmd_cond_test
    import rmd_pkg::*;
(
    input  wire logic [WORD_W-1:0] status_word,
    input  wire logic [WORD_W-1:0] cond_en,
    input  wire logic [WORD_W-1:0] cond_state,
    output logic                   met
);
    // A zero enable means no test at all
    always_comb begin
        met = (cond_en == '0) || ((status_word & cond_en) == (cond_state & cond_en));
    end
endmodule

//--- verilog/rmd_device.sv
// Device end: decodes register move, add to register and status check commands.
// Assumes the host sends one command at a time and waits for its answer.
//
// Behaviour
// - absolute move target comes from register N
// - time moves read accel N+1, time N+2
// - velocity moves read accel N+1, velocity N+2
// - relative move distance from register N
// - host gives starting index as first parameter
// - codes 236/235, four words each
// - codes 234/233, four words, same layout
// - register moves act like direct moves
// - add data into register, keep sum
// - add data is signed 32-bit
// - add command code 248, four words
// - moves only thread one; others both
// - status check uses jump condition test
// - true condition sets polling bit 6
// - zero enable sets bit 6 unconditionally
`timescale 1ns/1ps
module rmd_device
    import rmd_pkg::*;
#(
    parameter int N_DREG = 256
) (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      ce,
    rmd_link_if.dev                        link,
    input  wire logic [WORD_W-1:0]         status_word,
    input  wire logic                      psw_clear,
    input  wire logic                      ureg_we,
    input  wire logic [$clog2(N_DREG)-1:0] ureg_idx,
    input  wire logic [DATA_W-1:0]         ureg_wdata,
    output logic [DATA_W-1:0]              ureg_rdata_q,
    output logic [WORD_W-1:0]              psw_q,
    output logic                           move_start_q,
    output logic                           move_rel_q,
    output logic                           move_vel_q,
    output logic [DATA_W-1:0]              move_pos_q,
    output logic [DATA_W-1:0]              move_p1_q,
    output logic [DATA_W-1:0]              move_p2_q,
    output logic [WORD_W-1:0]              move_stop_en_q,
    output logic [WORD_W-1:0]              move_stop_st_q
);
    localparam int IDX_W = $clog2(N_DREG);

    // ************************************************************
    // State
    // ************************************************************
    rmd_dev_state_t    state_q;
    logic              rdy_q;
    logic              rsp_valid_q;
    logic              rsp_nak_q;
    logic [WORD_W-1:0] code_q;
    logic              thread_q;
    logic [2:0]        len_q;
    logic [2:0]        cnt_q;
    logic [WORD_W-1:0] pw_q [1:3];
    logic [DATA_W-1:0] dreg_q [N_DREG];

    assign link.cmd_ready = rdy_q;
    assign link.rsp_valid = rsp_valid_q;
    assign link.rsp_nak   = rsp_nak_q;

    // ************************************************************
    // Decode
    // ************************************************************
    function automatic logic [2:0] len_of(input logic [WORD_W-1:0] c);
        case (c)
            CODE_REG_MOVE_ABS_TIME,
            CODE_REG_MOVE_REL_TIME,
            CODE_REG_MOVE_ABS_VELOCITY,
            CODE_REG_MOVE_REL_VELOCITY: len_of = LEN_MOVE;
            CODE_ADD_TO_DATA_REGISTER:  len_of = LEN_ADD;
            CODE_CHECK_STATUS_REPORT:   len_of = LEN_CHECK;
            default:                    len_of = LEN_NONE;
        endcase
    endfunction

    logic              take;
    logic [2:0]        in_len;
    logic              is_move;
    logic              is_add;
    logic              is_check;
    logic              is_rel;
    logic              is_vel;
    logic [IDX_W-1:0]  idx;
    logic [IDX_W-1:0]  idx_p1;
    logic [IDX_W-1:0]  idx_p2;
    logic              move_fits;
    logic              add_fits;
    logic              exec_ok;
    logic              cond_met;
    logic [DATA_W-1:0] add_data;

    assign take     = link.cmd_valid && rdy_q;
    assign in_len   = len_of(link.cmd_word);
    assign is_rel   = (code_q == CODE_REG_MOVE_REL_TIME) || (code_q == CODE_REG_MOVE_REL_VELOCITY);
    assign is_vel   = (code_q == CODE_REG_MOVE_ABS_VELOCITY) || (code_q == CODE_REG_MOVE_REL_VELOCITY);
    assign is_move  = is_rel || is_vel || (code_q == CODE_REG_MOVE_ABS_TIME);
    assign is_add   = (code_q == CODE_ADD_TO_DATA_REGISTER);
    assign is_check = (code_q == CODE_CHECK_STATUS_REPORT);
    assign idx      = pw_q[PW_IDX][IDX_W-1:0];
    assign idx_p1   = IDX_W'(idx + IDX_W'(OFS_ACCEL));
    assign idx_p2   = IDX_W'(idx + IDX_W'(OFS_TOTAL));
    // An index block running past the file is refused rather than wrapped
    assign move_fits = (int'(pw_q[PW_IDX]) + OFS_TOTAL) < N_DREG;
    assign add_fits  = int'(pw_q[PW_IDX]) < N_DREG;
    assign add_data  = {pw_q[PW_DATA_HI], pw_q[PW_DATA_LO]};

    always_comb begin
        if (is_move) begin
            exec_ok = move_fits && (thread_q == THREAD_ONE);
        end else if (is_add) begin
            exec_ok = add_fits;
        end else begin
            exec_ok = is_check;
        end
    end

    rmd_cond_test u_cond (
        .status_word (status_word),
        .cond_en     (pw_q[PW_COND_EN]),
        .cond_state  (pw_q[PW_COND_ST]),
        .met         (cond_met)
    );

    // ************************************************************
    // Word reception and answer
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q     <= RMD_RX_CODE;
            rdy_q       <= 1'b1;
            rsp_valid_q <= 1'b0;
            rsp_nak_q   <= 1'b0;
            code_q      <= '0;
            thread_q    <= 1'b0;
            len_q       <= LEN_NONE;
            cnt_q       <= 3'h0;
        end else if (ce) begin
            rsp_valid_q <= 1'b0;
            case (state_q)
                RMD_RX_CODE: begin
                    if (take) begin
                        code_q   <= link.cmd_word;
                        thread_q <= link.cmd_thread;
                        len_q    <= in_len;
                        cnt_q    <= 3'h1;
                        if (in_len == LEN_NONE) begin
                            // Unknown code is refused on its first word
                            rsp_valid_q <= 1'b1;
                            rsp_nak_q   <= 1'b1;
                        end else begin
                            state_q <= RMD_RX_PARAM;
                        end
                    end
                end
                RMD_RX_PARAM: begin
                    if (take) begin
                        cnt_q <= 3'(cnt_q + 3'h1);
                        if (3'(cnt_q + 3'h1) == len_q) begin
                            rdy_q   <= 1'b0;
                            state_q <= RMD_EXEC;
                        end
                    end
                end
                RMD_EXEC: begin
                    rsp_valid_q <= 1'b1;
                    rsp_nak_q   <= !exec_ok;
                    rdy_q       <= 1'b1;
                    state_q     <= RMD_RX_CODE;
                end
                default: begin
                    rdy_q   <= 1'b1;
                    state_q <= RMD_RX_CODE;
                end
            endcase
        end
    end

    // Kept until the next command overwrites them
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pw_q <= '{default: '0};
        end else if (ce && take && (state_q == RMD_RX_PARAM)) begin
            pw_q[cnt_q] <= link.cmd_word;
        end
    end

    // ************************************************************
    // Data registers
    // ************************************************************
    // The add wins a same-cycle user write; the user write is lost
    always_ff @(posedge clk) begin
        if (ce) begin
            if ((state_q == RMD_EXEC) && is_add && add_fits) begin
                dreg_q[idx] <= DATA_W'(dreg_q[idx] + add_data);
            end else if (ureg_we) begin
                dreg_q[ureg_idx] <= ureg_wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ureg_rdata_q <= '0;
        end else if (ce) begin
            ureg_rdata_q <= dreg_q[ureg_idx];
        end
    end

    // ************************************************************
    // Move request to the profile generator
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            move_start_q   <= 1'b0;
            move_rel_q     <= 1'b0;
            move_vel_q     <= 1'b0;
            move_pos_q     <= '0;
            move_p1_q      <= '0;
            move_p2_q      <= '0;
            move_stop_en_q <= '0;
            move_stop_st_q <= '0;
        end else if (ce) begin
            move_start_q <= 1'b0;
            if ((state_q == RMD_EXEC) && is_move && exec_ok) begin
                move_start_q   <= 1'b1;
                move_rel_q     <= is_rel;
                move_vel_q     <= is_vel;
                move_pos_q     <= dreg_q[idx];
                move_p1_q      <= dreg_q[idx_p1];
                move_p2_q      <= dreg_q[idx_p2];
                move_stop_en_q <= pw_q[PW_STOP_EN];
                move_stop_st_q <= pw_q[PW_STOP_ST];
            end
        end
    end

    // ************************************************************
    // Polling status word
    // ************************************************************
    // Set wins over a clear in the same cycle so no report is lost
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            psw_q <= '0;
        end else if (ce) begin
            if ((state_q == RMD_EXEC) && is_check && cond_met) begin
                psw_q[PSW_CHECK_BIT] <= 1'b1;
            end else if (psw_clear) begin
                psw_q[PSW_CHECK_BIT] <= 1'b0;
            end
        end
    end
endmodule

//--- verilog/rmd_host.sv
// Host end: software loads command words over classic Wishbone and starts a send.
// Assumes the device answers every command once on the link.
`timescale 1ns/1ps
module rmd_host
    import rmd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    rmd_link_if.host         link,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o_q,
    output logic             wb_ack_o_q,
    output logic             irq_q
);
    // ************************************************************
    // Registers
    // ************************************************************
    rmd_host_state_t   state_q;
    logic [WORD_W-1:0] word_q [4];
    logic [2:0]        len_q;
    logic              thread_q;
    logic              nak_q;
    logic [1:0]        widx_q;
    logic              valid_q;
    logic [WORD_W-1:0] cw_q;
    logic [IRQ_W-1:0]  istat_q;
    logic [IRQ_W-1:0]  imask_q;

    assign link.cmd_valid  = valid_q;
    assign link.cmd_word   = cw_q;
    assign link.cmd_thread = thread_q;

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        merge = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                merge[8*b +: 8] = n[8*b +: 8];
            end
        end
    endfunction

    logic        wr;
    logic        go;
    logic        busy;
    logic [31:0] ctrl_rd;
    logic [31:0] ctrl_new;
    logic [2:0]  len_new;
    logic        sent_last;
    logic        rsp;

    // Writes land on the edge where the master sees ack
    assign wr       = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o_q;
    assign busy     = (state_q != RMD_H_IDLE);
    assign ctrl_rd  = {25'h0, len_q, 2'h0, thread_q, 1'b0};
    assign ctrl_new = merge(ctrl_rd, wb_dat_i, wb_sel_i);
    assign len_new  = ctrl_new[CTRL_LEN_LSB +: 3];
    // A go while busy or with a bad length is dropped
    assign go       = wr && (wb_adr_i == ADR_CTRL) && ctrl_new[CTRL_GO] && !busy
                      && (len_new != LEN_NONE) && (len_new <= LEN_MAX);
    assign sent_last = valid_q && link.cmd_ready && ({1'b0, widx_q} == 3'(len_q - 3'h1));
    assign rsp       = busy && link.rsp_valid;

    // ************************************************************
    // Wishbone slave
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wb_ack_o_q <= 1'b0;
            wb_dat_o_q <= '0;
        end else if (ce) begin
            wb_ack_o_q <= wb_cyc_i && wb_stb_i && !wb_ack_o_q;
            case (wb_adr_i)
                ADR_WORD0, ADR_WORD1,
                ADR_WORD2, ADR_WORD3: wb_dat_o_q <= {16'h0, word_q[wb_adr_i[3:2]]};
                ADR_CTRL:             wb_dat_o_q <= ctrl_rd;
                ADR_STAT:             wb_dat_o_q <= {30'h0, nak_q, busy};
                ADR_ISTAT:            wb_dat_o_q <= {30'h0, istat_q};
                ADR_IMASK:            wb_dat_o_q <= {30'h0, imask_q};
                default:              wb_dat_o_q <= '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            word_q   <= '{default: '0};
            len_q    <= LEN_NONE;
            thread_q <= 1'b0;
            imask_q  <= '0;
        end else if (ce && wr && !busy) begin
            // Command words and control are frozen while a send runs
            case (wb_adr_i)
                ADR_WORD0, ADR_WORD1,
                ADR_WORD2, ADR_WORD3: word_q[wb_adr_i[3:2]] <= WORD_W'(merge({16'h0, word_q[wb_adr_i[3:2]]},
                    wb_dat_i, wb_sel_i));
                ADR_CTRL: begin
                    len_q    <= len_new;
                    thread_q <= ctrl_new[CTRL_THREAD];
                end
                ADR_IMASK:            imask_q <= IRQ_W'(merge({30'h0, imask_q}, wb_dat_i, wb_sel_i));
                default: ;
            endcase
        end else if (ce && wr && (wb_adr_i == ADR_IMASK)) begin
            imask_q <= IRQ_W'(merge({30'h0, imask_q}, wb_dat_i, wb_sel_i));
        end
    end

    // ************************************************************
    // Send sequence
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= RMD_H_IDLE;
            widx_q  <= 2'h0;
            valid_q <= 1'b0;
            cw_q    <= '0;
            nak_q   <= 1'b0;
        end else if (ce) begin
            case (state_q)
                RMD_H_IDLE: begin
                    if (go) begin
                        state_q <= RMD_H_SEND;
                        widx_q  <= 2'h0;
                        valid_q <= 1'b1;
                        cw_q    <= word_q[0];
                    end
                end
                RMD_H_SEND: begin
                    if (rsp || sent_last) begin
                        // An early answer means the code itself was refused
                        valid_q <= 1'b0;
                        state_q <= rsp ? RMD_H_IDLE : RMD_H_WAIT;
                        nak_q   <= rsp && link.rsp_nak;
                    end else if (valid_q && link.cmd_ready) begin
                        widx_q <= 2'(widx_q + 2'h1);
                        cw_q   <= word_q[2'(widx_q + 2'h1)];
                    end
                end
                RMD_H_WAIT: begin
                    if (rsp) begin
                        nak_q   <= link.rsp_nak;
                        state_q <= RMD_H_IDLE;
                    end
                end
                default: state_q <= RMD_H_IDLE;
            endcase
        end
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    logic [IRQ_W-1:0] iset;
    logic [IRQ_W-1:0] iclr;
    assign iset[IRQ_DONE] = rsp && ((state_q == RMD_H_WAIT) || (state_q == RMD_H_SEND));
    assign iset[IRQ_NAK]  = rsp && link.rsp_nak;
    assign iclr = (wr && (wb_adr_i == ADR_ISTAT)) ? IRQ_W'(merge(32'h0, wb_dat_i, wb_sel_i)) : '0;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            istat_q <= '0;
            irq_q   <= 1'b0;
        end else if (ce) begin
            istat_q <= (istat_q & ~iclr) | iset;
            irq_q   <= |(((istat_q & ~iclr) | iset) & imask_q);
        end
    end
endmodule

//--- bench/rmd_link_sva.sv
// Checker for the command link between the two ends.
// Assumes one clock, wired beside the link interface.
`timescale 1ns/1ps
module rmd_link_sva
    import rmd_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              cmd_valid,
    input wire logic [WORD_W-1:0] cmd_word,
    input wire logic              cmd_thread,
    input wire logic              cmd_ready,
    input wire logic              rsp_valid,
    input wire logic              rsp_nak
);
    // ********************
    // Word count of the command in flight
    // ********************
    logic [2:0]  cnt_q;
    logic [15:0] code_q;
    logic        thr_q;
    wire acc = cmd_valid && cmd_ready;
    wire first_mv = acc && cnt_q == 3'h0 && cmd_word inside {[16'h00e9:16'h00ec]};
    wire known = cmd_word inside {[16'h00e9:16'h00ec], 16'h00f8, 16'h00a4};
    always_ff @(posedge clk) begin
        if (!rst_n || rsp_valid) cnt_q <= 3'h0;
        else if (acc) cnt_q <= cnt_q + 3'h1;
    end
    always_ff @(posedge clk) begin
        if (acc && cnt_q == 3'h0) begin
            code_q <= cmd_word;
            thr_q  <= cmd_thread;
        end
    end
    // ********************
    // Assertions
    // ********************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    rsp_one_cycle_a: assert property (rsp_valid |=> !rsp_valid)
        else $error("answer pulse too long");
    rsp_ready_a: assert property (rsp_valid |-> cmd_ready)
        else $error("link not ready at answer");
    nak_hold_a: assert property ($changed(rsp_nak) |-> rsp_valid)
        else $error("nak changed without answer");
    rsp_cause_a: assert property (rsp_valid |-> cnt_q != 3'h0)
        else $error("answer without command");
    reset_ready_a: assert property ($rose(rst_n) |-> cmd_ready)
        else $error("link not ready after reset");
    four_word_a: assert property (acc && cnt_q == 3'h3 && !thr_q && code_q inside {[16'h00e9:16'h00ec], 16'h00f8}
        |=> !cmd_ready && !rsp_valid ##1 rsp_valid)
        else $error("four word command timing");
    check_len_a: assert property (acc && cnt_q == 3'h2 && code_q == 16'h00a4
        |=> !cmd_ready ##1 rsp_valid && !rsp_nak)
        else $error("status check timing");
    move_thread_a: assert property (first_mv && cmd_thread |-> ##[1:20] rsp_valid && rsp_nak)
        else $error("move in thread two not refused");
    unknown_code_a: assert property (acc && cnt_q == 3'h0 && !known |=> rsp_valid && rsp_nak)
        else $error("unknown code not refused");
endmodule

//--- bench/tb.sv
// Bench joining host end and device end.
// Assumes Wishbone access to the host end.
`timescale 1ns/1ps
module tb;
    import rmd_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0, irq, ack, mask = 1'b1;
    logic        ureg_we = 1'b0, psw_clear = 1'b0, mrel, mvel, mstart;
    logic [7:0]  adr = 8'h0, ureg_idx = 8'h0;
    logic [15:0] status_word = 16'h0, psw, msen, msst;
    logic [31:0] dat = 32'h0, ureg_wdata = 32'h0, r, rdat, mpos, mp1, mp2, wbo;
    int          num_errors = 0, tests_run = 0, starts = 0;
    rmd_link_if u_rmd_link_if();
    rmd_host u_rmd_host(.clk, .rst_n, .ce(1'b1), .link(u_rmd_link_if), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o_q(wbo),
        .wb_ack_o_q(ack), .irq_q(irq));
    rmd_device u_rmd_device(.clk, .rst_n, .ce(1'b1), .link(u_rmd_link_if), .status_word,
        .psw_clear, .ureg_we, .ureg_idx, .ureg_wdata,
        .ureg_rdata_q(rdat), .psw_q(psw), .move_start_q(mstart), .move_rel_q(mrel), .move_vel_q(mvel),
        .move_pos_q(mpos), .move_p1_q(mp1), .move_p2_q(mp2), .move_stop_en_q(msen), .move_stop_st_q(msst));
    rmd_link_sva u_rmd_link_sva(.clk, .rst_n, .cmd_valid(u_rmd_link_if.cmd_valid),
        .cmd_word(u_rmd_link_if.cmd_word), .cmd_thread(u_rmd_link_if.cmd_thread),
        .cmd_ready(u_rmd_link_if.cmd_ready), .rsp_valid(u_rmd_link_if.rsp_valid),
        .rsp_nak(u_rmd_link_if.rsp_nak));
    always #10 clk = ~clk;
    always @(posedge clk) if (mstart === 1'b1) starts++;
    // ********************
    // Shared tasks
    // ********************
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        r = wbo;
        cyc <= 1'b0;
    endtask
    task automatic cmd(logic [15:0] w0, w1, w2, w3, logic [2:0] len, logic thr, logic [1:0] ist);
        logic [15:0] w [4] = '{w0, w1, w2, w3};
        int n = 0;
        for (int k = 0; k < 4; k++) wb(1'b1, 8'(4 * k), {16'h0, w[k]});
        wb(1'b1, ADR_CTRL, {25'h0, len, 2'h0, thr, 1'b1});
        while (irq !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        chk("irq", {31'h0, mask}, {31'h0, irq});
        wb(1'b0, ADR_ISTAT, 32'h0);
        chk("istat", {30'h0, ist}, r);
        wb(1'b1, ADR_ISTAT, 32'h3);
        repeat (2) @(posedge clk);
        chk("irq clear", 32'h0, {31'h0, irq});
    endtask
    task automatic ld(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        ureg_we <= 1'b1;
        ureg_idx <= a;
        ureg_wdata <= d;
        @(posedge clk);
        ureg_we <= 1'b0;
    endtask
    task automatic rdreg(logic [7:0] a, logic [31:0] e);
        @(posedge clk);
        ureg_idx <= a;
        repeat (2) @(posedge clk);
        chk("dreg", e, rdat);
    endtask
    // ********************
    // Scenarios
    // ********************
    task automatic move_tests();
        for (int i = 0; i < 3; i++) ld(8'hfd + 8'(i), 32'h8000_0001 + 32'(i));
        for (int i = 0; i < 4; i++) begin
            cmd(16'h00ec - 16'(i), 16'h00fd, 16'(i), 16'hff00, 3'h4, 1'b0, 2'h1);
            chk("pos", 32'h8000_0001, mpos);
            chk("p1", 32'h8000_0002, mp1);
            chk("p2", 32'h8000_0003, mp2);
            chk("kind", {30'h0, i[1], i[0]}, {30'h0, mvel, mrel});
            chk("stop", {16'(i), 16'hff00}, {msen, msst});
        end
        cmd(16'h00ec, 16'h00fe, 16'h0, 16'h0, 3'h4, 1'b0, 2'h3);
        cmd(16'h00ea, 16'h00fd, 16'h7, 16'h0, 3'h4, 1'b1, 2'h3);
        chk("stop kept", {16'h3, 16'hff00}, {msen, msst});
        chk("starts", 32'h4, starts);
    endtask
    task automatic add_tests();
        ld(8'h0a, 32'h5);
        mask = 1'b0;
        wb(1'b1, ADR_IMASK, 32'h0);
        cmd(16'h00f8, 16'h000a, 16'hffff, 16'hfffe, 3'h4, 1'b1, 2'h1);
        rdreg(8'h0a, 32'h3);
        mask = 1'b1;
        wb(1'b1, ADR_IMASK, 32'h3);
        cmd(16'h00f8, 16'h000a, 16'h0001, 16'h0000, 3'h4, 1'b0, 2'h1);
        rdreg(8'h0a, 32'h0001_0003);
        cmd(16'h00f8, 16'h0100, 16'h0, 16'h1, 3'h4, 1'b0, 2'h3);
    endtask
    task automatic chks(logic [15:0] en, st, sw, e);
        @(posedge clk);
        status_word <= sw;
        psw_clear <= 1'b1;
        @(posedge clk);
        psw_clear <= 1'b0;
        cmd(16'h00a4, en, st, 16'h0, 3'h3, sw[2], 2'h1);
        chk("psw", {16'h0, e}, {16'h0, psw});
    endtask
    task automatic end_sim();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        end_sim();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b1, ADR_IMASK, 32'h3);
        move_tests();
        add_tests();
        chks(16'h0, 16'h4, 16'h0, 16'h40);
        chks(16'h4, 16'h4, 16'h4, 16'h40);
        chks(16'h4, 16'h4, 16'h0, 16'h0);
        cmd(16'h0001, 16'h0, 16'h0, 16'h0, 3'h1, 1'b0, 2'h3);
        end_sim();
    end
endmodule
